// *** hdl/dccct_pkg.sv ***
// Package of constants and carriers for the common control and trigger register group.
package dccct_pkg;
  // Register addresses on the serial register interface.
  localparam logic [7:0] ADDR_COMMON_CFG = 8'h1F;
  localparam logic [7:0] ADDR_GEN_TRIG = 8'h20;
  localparam logic [7:0] ADDR_CHAN_TRIG = 8'h21;
  // Page and register addresses for the managed-bus path.
  localparam logic [7:0] PM_PAGE_COMMON = 8'hFF;
  localparam logic [7:0] PM_ADDR_COMMON_CFG = 8'hE3;
  localparam logic [7:0] PM_ADDR_GEN_TRIG = 8'hE4;
  localparam logic [7:0] PM_ADDR_CHAN_TRIG = 8'hE5;
  // Reset values.
  localparam logic [15:0] COMMON_CFG_RESET = 16'h0FFF;
  localparam logic [15:0] GEN_TRIG_RESET = 16'h0000;
  localparam logic [15:0] CHAN_TRIG_RESET = 16'h0000;
  // Common configuration field positions.
  localparam int CFG_HOLD_BIT = 15;
  localparam int CFG_FREEZE_BIT = 14;
  localparam int CFG_LOGSEL_BIT = 13;
  localparam int CFG_REFEN_BIT = 12;
  localparam int CFG_VPD0_LSB = 10;
  localparam int CFG_IPD0_BIT = 9;
  localparam int CFG_VPD1_LSB = 1;
  localparam int CFG_IPD1_BIT = 0;
  // Mask of the don't-care bits 8..3, which read their reset pattern.
  localparam logic [15:0] CFG_SPARE_MASK = 16'h01F8;
  // General trigger field positions and key values.
  localparam int TRG_PASS_LSB = 12;
  localparam int TRG_RESET_LSB = 8;
  localparam int TRG_UPDATE_BIT = 7;
  localparam int TRG_CLEAR_BIT = 6;
  localparam int TRG_DUMP_BIT = 4;
  localparam int TRG_GUARD_BIT = 3;
  localparam int TRG_ROWREAD_BIT = 2;
  localparam int TRG_PROG_BIT = 1;
  localparam int TRG_RESTORE_BIT = 0;
  localparam logic [3:0] UNFREEZE_KEY = 4'h5;
  localparam logic [3:0] SOFT_RESET_KEY = 4'hA;
  // Channel trigger positions: channel 0 at base 0, channel 1 at base 12.
  localparam int CH1_BASE = 12;
  localparam int CT_FLAGCLR_OFS = 3;
  localparam int CT_LOMARGIN_OFS = 2;
  localparam int CT_HIMARGIN_OFS = 1;
  localparam int CT_RUN_OFS = 0;
  // Error log start addresses.
  localparam logic [7:0] LOG_START_A = 8'h00;
  localparam logic [7:0] LOG_START_B = 8'h01;
  // Cycles a soft reset holds this group's registers in reset.
  localparam logic [3:0] SOFT_RESET_CYCLES = 4'h4;

  // Voltage output power-down encodings.
  typedef enum logic [1:0] {
    VPD_ON = 2'b00,
    VPD_10K = 2'b01,
    VPD_100K = 2'b10,
    VPD_HIZ = 2'b11
  } dccct_vpd_t;

  // Per-channel analog control settings.
  typedef struct packed {
    dccct_vpd_t voltPd;
    logic currPd;
    logic vPull10k;
    logic vPull100k;
    logic vHiZ;
  } dccct_chan_ctl_t;

  // Per-channel one-cycle action pulses and run level.
  typedef struct packed {
    logic flagClear;
    logic lowerMargin;
    logic upperMargin;
    logic waveRun;
  } dccct_chan_act_t;

  // Global one-cycle action pulses.
  typedef struct packed {
    logic softReset;
    logic syncUpdate;
    logic outClear;
    logic logDump;
    logic safeguard;
    logic rowRead;
    logic nvProgram;
    logic nvRestore;
  } dccct_global_act_t;
endpackage

// *** hdl/dccct_regs.sv ***
// Common configuration and trigger register group of a dual-channel converter.
`timescale 1ns/1ns
module dccct_regs (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Serial register port, already decoded by the interface front end.
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWdata,
  // Managed-bus path: page and register address select this group.
  input wire logic pmSelect,
  input wire logic [7:0] pmPage,
  // Read data back to the interface front end.
  output logic [15:0] regRdata,
  output logic regHit,
  // Configuration outputs.
  output logic windowCmpHoldSelect,
  output logic registerFreeze,
  output logic [7:0] errorLogStart,
  output logic internalRefEnable,
  output dccct_pkg::dccct_chan_ctl_t chan0Ctl,
  output dccct_pkg::dccct_chan_ctl_t chan1Ctl,
  // Action outputs.
  output dccct_pkg::dccct_global_act_t globalAct,
  output dccct_pkg::dccct_chan_act_t chan0Act,
  output dccct_pkg::dccct_chan_act_t chan1Act
);
  // Stored configuration word; spare bits always hold their reset pattern.
  logic [15:0] cfgReg;
  // Password seen since the last write to configuration.
  logic keyArmedReg;
  // Stored waveform run bits, one per channel.
  logic [1:0] runReg;
  // Pulse registers for global and channel actions.
  dccct_pkg::dccct_global_act_t gActReg;
  logic [1:0] flagClrReg;
  logic [1:0] loMarReg;
  logic [1:0] hiMarReg;
  // Soft reset stretch counter.
  logic [3:0] softCntReg;
  // Address decode.
  logic selCfg;
  logic selGen;
  logic selChan;
  logic pmOnPage;
  logic wrCfg;
  logic wrGen;
  logic wrChan;
  logic softReq;

  // The managed-bus path reaches this group only on the common page.
  assign pmOnPage = pmSelect && (pmPage == dccct_pkg::PM_PAGE_COMMON);

  // Both address maps decode onto the same three registers.
  always_comb begin
    if (pmSelect) begin
      selCfg = pmOnPage && (regAddr == dccct_pkg::PM_ADDR_COMMON_CFG);
      selGen = pmOnPage && (regAddr == dccct_pkg::PM_ADDR_GEN_TRIG);
      selChan = pmOnPage && (regAddr == dccct_pkg::PM_ADDR_CHAN_TRIG);
    end else begin
      selCfg = (regAddr == dccct_pkg::ADDR_COMMON_CFG);
      selGen = (regAddr == dccct_pkg::ADDR_GEN_TRIG);
      selChan = (regAddr == dccct_pkg::ADDR_CHAN_TRIG);
    end
  end

  // Configuration writes are refused while frozen, unless the key came first,
  // and trigger writes are refused while frozen except the password field.
  assign wrCfg = regWrite && selCfg && (!cfgReg[dccct_pkg::CFG_FREEZE_BIT] || keyArmedReg);
  assign wrGen = regWrite && selGen && !cfgReg[dccct_pkg::CFG_FREEZE_BIT];
  assign wrChan = regWrite && selChan && !cfgReg[dccct_pkg::CFG_FREEZE_BIT];
  assign regHit = selCfg || selGen || selChan;

  // Soft reset requested by the key value in the reset field.
  assign softReq = wrGen &&
    (regWdata[dccct_pkg::TRG_RESET_LSB +: 4] == dccct_pkg::SOFT_RESET_KEY);

  // Unlock key tracking. Only the exact key arms; anything else is ignored,
  // and the arm is spent by the next configuration write.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      keyArmedReg <= 1'b0;
    end else if (softCntReg != 4'h0) begin
      keyArmedReg <= 1'b0;
    end else if (regWrite && selGen &&
                 regWdata[dccct_pkg::TRG_PASS_LSB +: 4] == dccct_pkg::UNFREEZE_KEY) begin
      keyArmedReg <= 1'b1; // Accepted even while frozen, so the host can unlock.
    end else if (regWrite && selCfg) begin
      keyArmedReg <= 1'b0;
    end
  end

  // Configuration register. A frozen device accepts only a write made after
  // the key; that write may clear the freeze bit.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgReg <= dccct_pkg::COMMON_CFG_RESET;
    end else if (softCntReg != 4'h0) begin
      cfgReg <= dccct_pkg::COMMON_CFG_RESET; // Soft reset acts like power-on.
    end else if (wrCfg) begin
      // Spare bits keep their reset pattern whatever is written.
      cfgReg <= (regWdata & ~dccct_pkg::CFG_SPARE_MASK) |
                (dccct_pkg::COMMON_CFG_RESET & dccct_pkg::CFG_SPARE_MASK);
    end
  end

  // Soft reset stretch: hold this group's own registers in reset for a few cycles;
  // the softReset output still pulses for one cycle and the field itself never stores.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      softCntReg <= 4'h0;
    end else if (softReq) begin
      softCntReg <= dccct_pkg::SOFT_RESET_CYCLES;
    end else if (softCntReg != 4'h0) begin
      softCntReg <= softCntReg - 4'h1;
    end
  end

  // Global trigger pulses: each lasts one cycle and never stores, so the
  // register reads back zero once the action is taken.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gActReg <= '0;
    end else begin
      gActReg.softReset <= softReq;
      gActReg.syncUpdate <= wrGen && regWdata[dccct_pkg::TRG_UPDATE_BIT];
      gActReg.outClear <= wrGen && regWdata[dccct_pkg::TRG_CLEAR_BIT];
      gActReg.logDump <= wrGen && regWdata[dccct_pkg::TRG_DUMP_BIT];
      gActReg.safeguard <= wrGen && regWdata[dccct_pkg::TRG_GUARD_BIT];
      gActReg.rowRead <= wrGen && regWdata[dccct_pkg::TRG_ROWREAD_BIT];
      gActReg.nvProgram <= wrGen && regWdata[dccct_pkg::TRG_PROG_BIT];
      gActReg.nvRestore <= wrGen && regWdata[dccct_pkg::TRG_RESTORE_BIT];
    end
  end

  // Per-channel trigger bits. The same layout repeats with a base offset,
  // so one generate loop serves both channels.
  generate
    for (genvar ch = 0; ch < 2; ch++) begin : gChan
      localparam int B = (ch == 0) ? 0 : dccct_pkg::CH1_BASE;
      // Pulse bits self-clear; the run bit is stored and readable.
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          flagClrReg[ch] <= 1'b0;
          loMarReg[ch] <= 1'b0;
          hiMarReg[ch] <= 1'b0;
          runReg[ch] <= 1'b0;
        end else begin
          flagClrReg[ch] <= wrChan && regWdata[B + dccct_pkg::CT_FLAGCLR_OFS];
          loMarReg[ch] <= wrChan && regWdata[B + dccct_pkg::CT_LOMARGIN_OFS];
          hiMarReg[ch] <= wrChan && regWdata[B + dccct_pkg::CT_HIMARGIN_OFS];
          if (softCntReg != 4'h0) begin
            runReg[ch] <= 1'b0;
          end else if (wrChan) begin
            runReg[ch] <= regWdata[B + dccct_pkg::CT_RUN_OFS];
          end
        end
      end
    end
  endgenerate

  // Read mux. Triggers read zero, except the stored run bits.
  always_comb begin
    regRdata = 16'h0000;
    if (regRead && selCfg) begin
      regRdata = cfgReg;
    end else if (regRead && selGen) begin
      regRdata = dccct_pkg::GEN_TRIG_RESET; // Every field self-clears.
    end else if (regRead && selChan) begin
      regRdata = dccct_pkg::CHAN_TRIG_RESET;
      regRdata[dccct_pkg::CT_RUN_OFS] = runReg[0];
      regRdata[dccct_pkg::CH1_BASE + dccct_pkg::CT_RUN_OFS] = runReg[1];
    end
  end

  // Configuration fields straight from the stored word.
  assign windowCmpHoldSelect = cfgReg[dccct_pkg::CFG_HOLD_BIT];
  assign registerFreeze = cfgReg[dccct_pkg::CFG_FREEZE_BIT];
  assign internalRefEnable = cfgReg[dccct_pkg::CFG_REFEN_BIT];
  // Error log start address choice.
  assign errorLogStart = cfgReg[dccct_pkg::CFG_LOGSEL_BIT] ?
    dccct_pkg::LOG_START_B : dccct_pkg::LOG_START_A;

  // Channel analog controls decoded from the stored power-down fields.
  dccct_vpd_decode uDec0 (
    .voltCode(cfgReg[dccct_pkg::CFG_VPD0_LSB +: 2]),
    .currCode(cfgReg[dccct_pkg::CFG_IPD0_BIT]),
    .ctl(chan0Ctl)
  );
  dccct_vpd_decode uDec1 (
    .voltCode(cfgReg[dccct_pkg::CFG_VPD1_LSB +: 2]),
    .currCode(cfgReg[dccct_pkg::CFG_IPD1_BIT]),
    .ctl(chan1Ctl)
  );

  // Action outputs from flip-flops.
  assign globalAct = gActReg;
  assign chan0Act = '{flagClear: flagClrReg[0], lowerMargin: loMarReg[0],
                      upperMargin: hiMarReg[0], waveRun: runReg[0]};
  assign chan1Act = '{flagClear: flagClrReg[1], lowerMargin: loMarReg[1],
                      upperMargin: hiMarReg[1], waveRun: runReg[1]};
endmodule // dccct_regs

// *** hdl/dccct_vpd_decode.sv ***
// Decoder from a voltage power-down code to per-channel analog controls.
`timescale 1ns/1ns
module dccct_vpd_decode (
  // Configuration inputs.
  input wire logic [1:0] voltCode,
  input wire logic currCode,
  // Decoded controls.
  output dccct_pkg::dccct_chan_ctl_t ctl
);
  // Purely combinational: register outputs upstream already hold the state.
  always_comb begin
    ctl.voltPd = dccct_pkg::dccct_vpd_t'(voltCode);
    ctl.currPd = currCode;
    ctl.vPull10k = 1'b0;
    ctl.vPull100k = 1'b0;
    ctl.vHiZ = 1'b0;
    case (dccct_pkg::dccct_vpd_t'(voltCode))
      dccct_pkg::VPD_ON: begin
        ctl.vHiZ = 1'b0; // Output powered up.
      end
      dccct_pkg::VPD_10K: begin
        ctl.vPull10k = 1'b1; // Down with the 10k pulldown.
      end
      dccct_pkg::VPD_100K: begin
        ctl.vPull100k = 1'b1; // Down with the 100k pulldown.
      end
      default: begin
        ctl.vHiZ = 1'b1; // High-impedance power-down.
      end
    endcase
  end
endmodule // dccct_vpd_decode

// *** verification/dccct_host_model.sv ***
// Host model that drives the register port one word at a time.
`timescale 1ns/1ns
module dccct_host_model (
  // Clock.
  input wire logic clk,
  // Register port toward the device.
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [15:0] regWdata,
  output logic pmSelect,
  output logic [7:0] pmPage
);
  // Idle values from time zero; the address rests on an unmapped place.
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h30;
    regWdata = 16'h0000;
    pmSelect = 1'b0;
    pmPage = 8'h00;
  end
  // One transfer: raised after an edge, taken by the device at the next edge.
  task automatic xfer(input logic wr, input logic pm, input logic [7:0] page,
    input logic [7:0] addr, input logic [15:0] data);
    @(posedge clk);
    regWrite <= wr;
    regRead <= !wr;
    pmSelect <= pm;
    pmPage <= page;
    regAddr <= addr;
    regWdata <= data;
    @(posedge clk);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    // Released data is inverted so a stale word never looks valid.
    regWdata <= ~data;
  endtask
endmodule // dccct_host_model

// *** verification/dccct_regs_monitor.sv ***
// Checker of the common control and trigger register group, seen from its ports.
`timescale 1ns/1ns
module dccct_regs_monitor (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Register port.
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic pmSelect,
  input wire logic [7:0] pmPage,
  input wire logic [15:0] regRdata,
  input wire logic regHit,
  // Configuration and action outputs.
  input wire logic windowCmpHoldSelect,
  input wire logic registerFreeze,
  input wire logic [7:0] errorLogStart,
  input wire logic internalRefEnable,
  input dccct_pkg::dccct_chan_ctl_t chan0Ctl,
  input dccct_pkg::dccct_chan_ctl_t chan1Ctl,
  input dccct_pkg::dccct_global_act_t globalAct,
  input dccct_pkg::dccct_chan_act_t chan0Act,
  input dccct_pkg::dccct_chan_act_t chan1Act
);
  default clocking mcb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Serial-map accesses; the managed path is checked on its hit flag alone.
  wire genWr = regWrite && !pmSelect && regAddr == 8'h20;
  // A trigger write that the freeze does not refuse.
  wire genGo = genWr && !registerFreeze;
  wire chWr = regWrite && !pmSelect && regAddr == 8'h21 && !registerFreeze;
  wire cfgRd = regRead && !pmSelect && regAddr == 8'h1F;
  // Channel trigger read, the only place the run levels show on the bus.
  wire chRd = regRead && !pmSelect && regAddr == 8'h21;
  sync_pulse_a: assert property (genGo && regWdata[7] |=> globalAct.syncUpdate)
    else $error("Update pulse missing.");
  clear_pulse_a: assert property (genGo && regWdata[6] |=> globalAct.outClear)
    else $error("Clear pulse missing.");
  dump_pulse_a: assert property (genGo && regWdata[4] ##1 !regWrite
    |-> globalAct.logDump ##1 !globalAct.logDump)
    else $error("Dump pulse wrong.");
  soft_reset_a: assert property (genGo && regWdata[11:8] == 4'hA
    |=> globalAct.softReset)
    else $error("Soft reset missing.");
  reset_key_a: assert property (genWr && regWdata[11:8] != 4'hA
    |=> !globalAct.softReset)
    else $error("Soft reset on wrong key.");
  freeze_hold_a: assert property (registerFreeze && genWr |=> globalAct == '0)
    else $error("Action while frozen.");
  trig_read_a: assert property (regRead && !pmSelect && regAddr == 8'h20
    |-> regRdata == 16'h0000)
    else $error("Trigger reads nonzero.");
  spare_bits_a: assert property (cfgRd |-> (regRdata & 16'h01F8) == 16'h01F8)
    else $error("Spare bits wrong.");
  log_start_a: assert property (cfgRd
    |-> errorLogStart == (regRdata[13] ? 8'h01 : 8'h00))
    else $error("Log start wrong.");
  power_down_a: assert property (cfgRd
    |-> chan0Ctl.voltPd == regRdata[11:10] && chan1Ctl.currPd == regRdata[0] &&
    chan0Ctl.vHiZ == (regRdata[11:10] == 2'b11) && internalRefEnable == regRdata[12])
    else $error("Decoded controls wrong.");
  pull_decode_a: assert property (cfgRd
    |-> chan1Ctl.voltPd == regRdata[2:1] && chan0Ctl.currPd == regRdata[9] &&
    chan1Ctl.vPull10k == (regRdata[2:1] == 2'b01) &&
    chan1Ctl.vPull100k == (regRdata[2:1] == 2'b10) &&
    chan0Ctl.vPull10k == (regRdata[11:10] == 2'b01) &&
    chan1Ctl.vHiZ == (regRdata[2:1] == 2'b11))
    else $error("Pulldown controls wrong.");
  cfg_fields_a: assert property (cfgRd
    |-> windowCmpHoldSelect == regRdata[15] && registerFreeze == regRdata[14])
    else $error("Config outputs wrong.");
  run_level_a: assert property (chRd
    |-> chan0Act.waveRun == regRdata[0] && chan1Act.waveRun == regRdata[12])
    else $error("Run level wrong.");
  unmapped_read_a: assert property (regRead && !regHit |-> regRdata == 16'h0000)
    else $error("Unmapped read nonzero.");
  page_hit_a: assert property (pmSelect && pmPage == 8'hFF
    && regAddr inside {8'hE3, 8'hE4, 8'hE5} |-> regHit)
    else $error("Managed page missed.");
  margin_pulse_a: assert property (chWr && regWdata[14] |=> chan1Act.lowerMargin)
    else $error("Margin pulse missing.");
endmodule // dccct_regs_monitor
bind dccct_regs dccct_regs_monitor u_mon (.clk(clk), .rst_n(rst_n), .regWrite(regWrite),
  .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .pmSelect(pmSelect),
  .pmPage(pmPage), .regRdata(regRdata), .regHit(regHit),
  .windowCmpHoldSelect(windowCmpHoldSelect), .registerFreeze(registerFreeze),
  .errorLogStart(errorLogStart), .internalRefEnable(internalRefEnable), .chan0Ctl(chan0Ctl),
  .chan1Ctl(chan1Ctl), .globalAct(globalAct), .chan0Act(chan0Act), .chan1Act(chan1Act));

// *** verification/dccct_regs_test.sv ***
// Self-checking bench of the common control and trigger register group.
`timescale 1ns/1ns
module dccct_regs_test;
  // Clock, reset and port nets.
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic regWrite, regRead, pmSelect, regHit, windowCmpHoldSelect, registerFreeze;
  logic internalRefEnable;
  logic [7:0] regAddr, pmPage, errorLogStart;
  logic [15:0] regWdata, regRdata, d;
  dccct_pkg::dccct_chan_ctl_t chan0Ctl, chan1Ctl;
  dccct_pkg::dccct_global_act_t globalAct;
  dccct_pkg::dccct_chan_act_t chan0Act, chan1Act;
  // Expected results, oldest first, and the tallies.
  logic [15:0] readQ[$];
  logic [13:0] actQ[$];
  int badCount = 0;
  int checksDone = 0;
  logic [31:0] lfsr = 32'h000161DA;
  int genBits[7] = '{7, 6, 4, 3, 2, 1, 0};
  int chanBits[6] = '{3, 2, 1, 15, 14, 13};
  // Pulses only; the run level is checked by reading it back.
  wire [13:0] actNow = {globalAct, chan0Act[3:1], chan1Act[3:1]};
  always #20 clk = ~clk;
  dccct_host_model u_host (.clk(clk), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .pmSelect(pmSelect), .pmPage(pmPage));
  dccct_regs u_dut (.clk(clk), .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .pmSelect(pmSelect), .pmPage(pmPage),
    .regRdata(regRdata), .regHit(regHit), .windowCmpHoldSelect(windowCmpHoldSelect),
    .registerFreeze(registerFreeze), .errorLogStart(errorLogStart),
    .internalRefEnable(internalRefEnable), .chan0Ctl(chan0Ctl), .chan1Ctl(chan1Ctl),
    .globalAct(globalAct), .chan0Act(chan0Act), .chan1Act(chan1Act));
  // Next value of the stimulus generator.
  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Compare tasks, one for each kind of result.
  task automatic compare_read(input logic [15:0] got);
    checksDone++;
    if (readQ.size() == 0 || got !== readQ[0]) begin
      badCount++;
      $display("ERROR %0t read data %h unexpected", $time, got);
    end
    if (readQ.size() != 0) void'(readQ.pop_front());
  endtask
  task automatic compare_act(input logic [13:0] got);
    checksDone++;
    if (actQ.size() == 0 || got !== actQ[0]) begin
      badCount++;
      $display("ERROR %0t action pulses %h unexpected", $time, got);
    end
    if (actQ.size() != 0) void'(actQ.pop_front());
  endtask
  // Write and read helpers; each notes what it expects before driving.
  task automatic wr(input logic [7:0] addr, input logic [15:0] data, input logic [13:0] act);
    if (act !== 14'h0) actQ.push_back(act);
    u_host.xfer(1'b1, 1'b0, 8'h00, addr, data);
  endtask
  task automatic rd(input logic pm, input logic [7:0] page, addr, input logic [15:0] exp);
    readQ.push_back(exp);
    u_host.xfer(1'b0, pm, page, addr, 16'h0000);
  endtask
  // Watcher: mid-cycle, each read or pulse takes the oldest note of its kind.
  always @(negedge clk) begin
    if (regRead === 1'b1) compare_read(regRdata);
    if (actNow !== 14'h0) compare_act(actNow);
  end
  // Verdict; a note left unmatched counts as a mismatch.
  task automatic reportAndStop();
    if (readQ.size() + actQ.size() != 0) badCount++;
    $display("Checks %0d, mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Watchdog against a hang.
  initial begin
    repeat (5000) @(posedge clk);
    badCount++;
    reportAndStop();
  end
  // Main sequence.
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(1'b0, 8'h00, 8'h1F, 16'h0FFF);
    rd(1'b0, 8'h00, 8'h21, 16'h0000);
    $display("Test reset values done");
    for (int i = 0; i < 7; i++) begin
      wr(8'h20, 16'h1 << genBits[i], 14'h1000 >> i);
    end
    rd(1'b0, 8'h00, 8'h20, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      wr(8'h21, 16'h1 << chanBits[i], 14'h0020 >> i);
    end
    wr(8'h21, 16'h1001, 14'h0);
    rd(1'b0, 8'h00, 8'h21, 16'h1001);
    $display("Test triggers done");
    // Random words with each power-down code on both channels, in four opposite pairs; freeze stays clear.
    for (int k = 0; k < 4; k++) begin
      lfsr = nextRand(lfsr);
      d = lfsr[15:0] & 16'hB3F9 | 16'(k) << 10 | 16'(3 - k) << 1;
      wr(8'h1F, d, 14'h0);
      rd(1'b0, 8'h00, 8'h1F, d | dccct_pkg::CFG_SPARE_MASK);
    end
    $display("Test configuration done");
    wr(8'h1F, 16'h4FFF, 14'h0);
    wr(8'h20, 16'h0080, 14'h0);
    wr(8'h21, 16'h4000, 14'h0);
    wr(8'h1F, 16'h0FFF, 14'h0);
    wr(8'h20, 16'h3000, 14'h0);
    wr(8'h1F, 16'h0FFF, 14'h0);
    rd(1'b0, 8'h00, 8'h1F, 16'h4FFF);
    wr(8'h20, 16'h5000, 14'h0);
    wr(8'h1F, 16'h1FFF, 14'h0);
    rd(1'b0, 8'h00, 8'h1F, 16'h1FFF);
    $display("Test freeze done");
    wr(8'h21, 16'h0001, 14'h0);
    wr(8'h20, 16'h0900, 14'h0);
    wr(8'h20, 16'h0A00, 14'h2000);
    repeat (6) @(posedge clk);
    rd(1'b0, 8'h00, 8'h1F, 16'h0FFF);
    rd(1'b0, 8'h00, 8'h21, 16'h0000);
    rd(1'b1, 8'hFF, 8'hE3, 16'h0FFF);
    rd(1'b1, 8'h00, 8'hE3, 16'h0000);
    rd(1'b1, 8'hFF, 8'hE4, 16'h0000);
    rd(1'b1, 8'hFF, 8'hE5, 16'h0000);
    // A managed-path trigger on the common page pulses; on another page it must not.
    actQ.push_back(14'h1000);
    u_host.xfer(1'b1, 1'b1, 8'hFF, 8'hE4, 16'h0080);
    u_host.xfer(1'b1, 1'b1, 8'h00, 8'hE4, 16'h0080);
    rd(1'b0, 8'h00, 8'h30, 16'h0000);
    $display("Test soft reset and addressing done");
    reportAndStop();
  end
endmodule // dccct_regs_test
